/* File: design/spc_fifo.sv */
`default_nettype none
// Synchronous FIFO with valid and ready on both sides
module spc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // Honest full and empty
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // Storage
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* File: design/spc_port.sv */
`default_nettype none
// Serial port with configurable role, polarity, phase and pin release
module spc_port (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address channel
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // Write data channel
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // Write response channel
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // Read address channel
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // Read data channel
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Serial clock pin
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    // Serial data pins
    input  wire logic        sdi_in,
    output logic             sdo_out,
    output logic             sdo_oe,
    // Slave select pin
    input  wire logic        ss_in_n,
    // Link to framed-mode logic
    output logic             framed_operation_enable
);
    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0]          serial_port_control_one;
    logic [15:0]          ctrl2;
    logic                 aw_got;
    logic                 w_got;
    logic [4:0]           aw_addr_q;
    logic [31:0]          w_data_q;
    logic [3:0]           w_strb_q;
    logic                 wr_is_data;
    logic                 wr_go;
    logic [31:0]          rd_mux;
    logic                 rx_take;
    logic [15:0]          rx_word;
    logic                 rx_full;
    logic                 rx_ovf;
    logic                 ovf_set;
    logic                 ovf_clr;
    logic                 fifo_in_ready;
    logic [15:0]          fifo_out_data;
    logic                 fifo_out_valid;
    logic                 fifo_pop;
    logic                 sck_s1;
    logic                 sck_s2;
    logic                 sck_s3;
    logic                 sdi_s1;
    logic                 sdi_s2;
    logic                 ss_s1;
    logic                 ss_s2;
    spc_pkg::spc_shift_t  state;
    logic [5:0]           k;
    logic [9:0]           div_cnt;
    logic [15:0]          sh_tx;
    logic [15:0]          sh_rx;
    logic                 master_role_enable;
    logic                 clock_polarity_select;
    logic                 sample_phase_select;
    logic                 word_byte_select;
    logic                 edge_sel;
    logic                 select_pin_enable;
    logic                 port_en;
    logic                 slave_sel;
    logic                 run_ok;
    logic [9:0]           half;
    logic                 tick;
    logic                 ev;
    logic [5:0]           last_k;
    logic [5:0]           end_k;
    logic                 do_samp;
    logic                 do_shift;
    logic [15:0]          tx_load;

    ////////////////////////////////////////////////////////////////////////////////
    // Field decode
    assign master_role_enable    = serial_port_control_one[spc_pkg::B_MASTER];
    assign clock_polarity_select = serial_port_control_one[spc_pkg::B_POL];
    assign word_byte_select      = serial_port_control_one[spc_pkg::B_WIDE];
    assign edge_sel              = serial_port_control_one[spc_pkg::B_EDGE];
    assign select_pin_enable     = serial_port_control_one[spc_pkg::B_SEL_EN];
    assign port_en               = ctrl2[spc_pkg::B_PORT_EN];
    assign framed_operation_enable = ctrl2[spc_pkg::B_FRAMED];

    // Phase bit acts in master only; slave always samples mid-bit
    assign sample_phase_select = serial_port_control_one[spc_pkg::B_PHASE]
                                 && master_role_enable;
    // Select pin gates the slave only when enabled
    assign slave_sel = !select_pin_enable || !ss_s2;
    assign run_ok    = port_en && (master_role_enable || slave_sel);

    ////////////////////////////////////////////////////////////////////////////////
    // Edge scheduling
    assign half = spc_pkg::half_period(serial_port_control_one[spc_pkg::B_PRIMARY_PRESCALE +: 2],
                                       serial_port_control_one[spc_pkg::B_SECONDARY_PRESCALE +: 3]);
    assign tick   = (div_cnt == half - 10'h001);
    // Master counts its own half periods, slave follows pin edges
    assign ev     = master_role_enable ? tick : (sck_s2 != sck_s3);
    assign last_k = word_byte_select ? spc_pkg::K_WORD : spc_pkg::K_BYTE;
    assign end_k  = master_role_enable ? last_k : last_k - 6'h01;
    // Even edge count is the leading edge of a bit
    assign do_samp  = edge_sel ? (sample_phase_select ? k[0] : !k[0] && k != last_k)
                               : (sample_phase_select ? (!k[0] && k != '0) : k[0]);
    assign do_shift = edge_sel ? k[0] : (!k[0] && k != '0);

    // First word to send, bytes left-aligned for MSB-first shifting
    assign tx_load  = !fifo_out_valid ? '0 :
                      word_byte_select ? fifo_out_data
                                       : {fifo_out_data[7:0], 8'h00};
    assign fifo_pop = (state == spc_pkg::SH_IDLE) && run_ok && fifo_out_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit FIFO between the bus and the shifter
    spc_fifo #(
        .WIDTH (spc_pkg::WORD_W),
        .DEPTH (spc_pkg::TX_DEPTH)
    ) u_tx_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_data   (w_data_q[15:0]),
        .in_valid  (wr_go && wr_is_data),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus write side: address and data taken in either order
    assign wr_is_data = (aw_addr_q == spc_pkg::ADDR_DATA);
    assign wr_go      = aw_got && w_got && !bvalid && !(wr_is_data && !fifo_in_ready);

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got    <= 1'b0;
            awready   <= 1'b0;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_got    <= 1'b1;
            awready   <= 1'b0;
            aw_addr_q <= awaddr;
        end else if (wr_go) begin
            aw_got <= 1'b0;
        end else if (!aw_got && !bvalid) begin
            awready <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got    <= 1'b0;
            wready   <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (wvalid && wready) begin
            w_got    <= 1'b1;
            wready   <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (wr_go) begin
            w_got <= 1'b0;
        end else if (!w_got && !bvalid) begin
            wready <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= spc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= spc_pkg::reg_hit(aw_addr_q) ? spc_pkg::RESP_OKAY
                                                  : spc_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_port_control_one <= spc_pkg::CTRL1_RST;
            ctrl2                   <= spc_pkg::CTRL2_RST;
        end else if (wr_go && aw_addr_q == spc_pkg::ADDR_CTRL1) begin
            serial_port_control_one <= spc_pkg::wr_merge(serial_port_control_one,
                                                         w_data_q, w_strb_q)
                                       & spc_pkg::CTRL1_MASK;
        end else if (wr_go && aw_addr_q == spc_pkg::ADDR_CTRL2) begin
            ctrl2 <= spc_pkg::wr_merge(ctrl2, w_data_q, w_strb_q) & spc_pkg::CTRL2_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus read side
    assign rx_take = arvalid && arready && (araddr == spc_pkg::ADDR_DATA);

    // Read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (araddr)
            spc_pkg::ADDR_CTRL1: rd_mux = {16'h0000, serial_port_control_one};
            spc_pkg::ADDR_CTRL2: rd_mux = {16'h0000, ctrl2};
            spc_pkg::ADDR_DATA:  rd_mux = {16'h0000, rx_word};
            spc_pkg::ADDR_STAT: begin
                rd_mux[spc_pkg::B_TX_FULL]  = !fifo_in_ready;
                rd_mux[spc_pkg::B_TX_EMPTY] = !fifo_out_valid;
                rd_mux[spc_pkg::B_RX_FULL]  = rx_full;
                rd_mux[spc_pkg::B_RX_OVF]   = rx_ovf;
                rd_mux[spc_pkg::B_BUSY]     = (state != spc_pkg::SH_IDLE);
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read address and data channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= spc_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= spc_pkg::reg_hit(araddr) ? spc_pkg::RESP_OKAY
                                                : spc_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive word and flags; a new word wins over a clear
    assign ovf_set = (state == spc_pkg::SH_END) && rx_full && !rx_take;
    assign ovf_clr = wr_go && aw_addr_q == spc_pkg::ADDR_STAT && w_strb_q[0]
                     && w_data_q[spc_pkg::B_RX_OVF];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_word <= '0;
            rx_full <= 1'b0;
        end else if (state == spc_pkg::SH_END) begin
            rx_word <= word_byte_select ? sh_rx : {8'h00, sh_rx[7:0]};
            rx_full <= 1'b1;
        end else if (rx_take) begin
            rx_full <= 1'b0;
        end
    end

    // Overflow flag, write one to clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_ovf <= 1'b0;
        end else if (ovf_set) begin
            rx_ovf <= 1'b1;
        end else if (ovf_clr) begin
            rx_ovf <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
            ss_s1  <= 1'b1;
            ss_s2  <= 1'b1;
        end else begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            sdi_s1 <= sdi_in;
            sdi_s2 <= sdi_s1;
            ss_s1  <= ss_in_n;
            ss_s2  <= ss_s1;
        end
    end

    // Half-period divider for master clock generation
    always_ff @(posedge aclk) begin
        if (!aresetn || state != spc_pkg::SH_RUN || tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shifter sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= spc_pkg::SH_IDLE;
            k       <= '0;
            sh_tx   <= '0;
            sh_rx   <= '0;
            sdo_out <= 1'b0;
        end else if (!run_ok || (wr_go && aw_addr_q == spc_pkg::ADDR_CTRL1)) begin
            state <= spc_pkg::SH_IDLE;
            k     <= '0;
        end else begin
            unique case (state)
                spc_pkg::SH_IDLE: begin
                    if (!master_role_enable || fifo_out_valid) begin
                        sh_tx   <= tx_load;
                        sdo_out <= tx_load[15];
                        k       <= '0;
                        state   <= spc_pkg::SH_RUN;
                    end
                end
                spc_pkg::SH_RUN: begin
                    if (ev) begin
                        if (do_samp) begin
                            sh_rx <= {sh_rx[14:0], sdi_s2};
                        end
                        if (do_shift) begin
                            sh_tx   <= {sh_tx[14:0], 1'b0};
                            sdo_out <= sh_tx[14];
                        end
                        if (k == end_k) begin
                            state <= spc_pkg::SH_END;
                        end else begin
                            k <= k + 6'h01;
                        end
                    end
                end
                spc_pkg::SH_END: begin
                    state <= spc_pkg::SH_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock: idles at polarity level, driven only by a master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_out <= 1'b0;
        end else if (!master_role_enable || state != spc_pkg::SH_RUN) begin
            sck_out <= clock_polarity_select;
        end else if (tick && k < last_k) begin
            sck_out <= k[0] ? clock_polarity_select : !clock_polarity_select;
        end
    end

    // Pin enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_oe <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sck_oe <= port_en && master_role_enable
                      && !serial_port_control_one[spc_pkg::B_CLK_DIS];
            sdo_oe <= port_en && !serial_port_control_one[spc_pkg::B_DO_DIS]
                      && (master_role_enable || slave_sel);
        end
    end
endmodule
`default_nettype wire

/* File: inc/spc_pkg.sv */
// How it works
// - Role bit selects master or slave operation
// - Master clock-pin disable releases clock pin
// - Data-out disable releases the data pin
// - Sample phase in master; slave forces zero
// - Polarity bit sets clock idle level
// - Slave uses select pin only when enabled
`default_nettype none
package spc_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int         ADDR_W     = 5;
    localparam logic [4:0] ADDR_CTRL1 = 5'h00;
    localparam logic [4:0] ADDR_CTRL2 = 5'h04;
    localparam logic [4:0] ADDR_DATA  = 5'h08;
    localparam logic [4:0] ADDR_STAT  = 5'h0C;

    // Control one fields
    localparam int          B_CLK_DIS  = 12;
    localparam int          B_DO_DIS   = 11;
    localparam int          B_WIDE     = 10;
    localparam int          B_PHASE    = 9;
    localparam int          B_EDGE     = 8;
    localparam int          B_SEL_EN   = 7;
    localparam int          B_POL      = 6;
    localparam int          B_MASTER   = 5;
    localparam int          B_SECONDARY_PRESCALE     = 2;
    localparam int          B_PRIMARY_PRESCALE     = 0;
    localparam logic [15:0] CTRL1_RST  = 16'h0000;
    localparam logic [15:0] CTRL1_MASK = 16'h1FFF;

    // Control two fields
    localparam int          B_PORT_EN  = 0;
    localparam int          B_FRAMED   = 1;
    localparam logic [15:0] CTRL2_RST  = 16'h0000;
    localparam logic [15:0] CTRL2_MASK = 16'h0003;

    // Status fields
    localparam int B_TX_FULL  = 0;
    localparam int B_TX_EMPTY = 1;
    localparam int B_RX_FULL  = 2;
    localparam int B_RX_OVF   = 3;
    localparam int B_BUSY     = 4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Shifter sizes and edge counts
    localparam int         WORD_W   = 16;
    localparam int         TX_DEPTH = 16;
    localparam logic [5:0] K_WORD   = 6'h20;
    localparam logic [5:0] K_BYTE   = 6'h10;
    localparam logic [3:0] SEC_BASE = 4'h8;
    localparam logic [6:0] PRI_UNIT = 7'h01;

    // Shifter state
    typedef enum logic [1:0] {SH_IDLE, SH_RUN, SH_END} spc_shift_t;

    // Half clock period in system cycles from both prescalers
    function automatic logic [9:0] half_period(logic [1:0] pri, logic [2:0] sec);
        logic [6:0] p;
        logic [3:0] s;
        p = PRI_UNIT << {pri ^ 2'h3, 1'b0};
        s = SEC_BASE - {1'b0, sec};
        half_period = {3'h0, p} * {6'h00, s};
    endfunction

    // Byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] wr_merge(logic [15:0] old, logic [31:0] d,
                                             logic [3:0] strb);
        wr_merge = old;
        if (strb[0]) wr_merge[7:0] = d[7:0];
        if (strb[1]) wr_merge[15:8] = d[15:8];
    endfunction

    // Decode of mapped offsets
    function automatic logic reg_hit(logic [4:0] a);
        reg_hit = (a == ADDR_CTRL1) || (a == ADDR_CTRL2) ||
                  (a == ADDR_DATA) || (a == ADDR_STAT);
    endfunction
endpackage
`default_nettype wire

/* File: sim/spc_peer.sv */
`default_nettype none
// Far-side device: slave to our master, or master clocking our slave
module spc_peer (
    // Clock idle level
    input  wire logic pol,
    // Pins
    input  wire logic sck_pin,
    input  wire logic sdo_pin,
    output logic      sdi,
    output logic      sck_drv,
    output var logic  ss_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] tx = 16'h0000;
    logic [15:0] rx = 16'h0000;
    logic        act = 1'b0;
    initial ss_n = 1'b1;
    // Own clock rests at the idle level outside frames
    assign sck_drv = pol ^ act;
    assign sdi = tx[15];
    // Leading edge captures, trailing edge shifts, top bit first
    always @(sck_pin) begin
        if (sck_pin !== pol) rx = {rx[14:0], sdo_pin};
        else tx = {tx[14:0], ~tx[0]};
    end
    // One selected frame at a 400 ns clock period
    task automatic frame(input int bits);
        #5 ss_n = 1'b0;
        #400;
        repeat (2 * bits) begin
            act = ~act;
            #200;
        end
        ss_n = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: sim/spc_port_props.sv */
`default_nettype none
// Port-level checks of the serial port
module spc_port_props (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [4:0]  awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    // Pins
    input wire logic        sck_oe,
    input wire logic        sdo_oe,
    input wire logic        ss_in_n
);
    logic [4:0]  wa;
    logic [12:0] wd;
    logic [12:0] sh;
    wire logic   quiet = !bvalid;
    wire logic   slv = quiet && !sh[spc_pkg::B_MASTER];
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Shadow of control one, taken once its write is answered
    always_ff @(posedge aclk) begin
        if (awvalid && awready) wa <= awaddr;
        if (wvalid && wready) wd <= wdata[12:0];
        if (!aresetn) sh <= 13'h0000;
        else if (bvalid && bready && wa == spc_pkg::ADDR_CTRL1) sh <= wd;
    end
    role_slave_a: assert property (slv |-> !sck_oe)
        else $error("slave role drives the clock pin");
    clk_release_a: assert property (quiet && !slv && sh[spc_pkg::B_CLK_DIS] |-> !sck_oe)
        else $error("released clock pin still driven");
    data_release_a: assert property (quiet && sh[spc_pkg::B_DO_DIS] |-> !sdo_oe)
        else $error("released data pin still driven");
    sel_gate_a: assert property ((slv && sh[spc_pkg::B_SEL_EN] && ss_in_n) [*6] |-> !sdo_oe)
        else $error("deselected slave drives data");
    wr_drop_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer not withdrawn");
    wr_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken before answer");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    rd_drop_a: assert property (rvalid && rready |=> !rvalid && !arready)
        else $error("read answer not withdrawn");
    cover property (bvalid && bready);
    cover property (rvalid && rready);
    cover property (sck_oe);
endmodule
bind spc_port spc_port_props chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .sck_oe,
    .sdo_oe, .ss_in_n);
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin fails++; \
    $display("Error %s expected %h seen %h", what, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ppol;
    logic        awready, wready, bvalid, arready, rvalid, sck_out, sck_oe, sdo_out, sdo_oe;
    logic        peer_sck, sdi, ss_n, fr;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v, s;
    logic [15:0] d, pw;
    logic [1:0]  bresp, rresp, r;
    int          fails, n_checks, i;
    wire logic   sck_pin = sck_oe ? sck_out : peer_sck;
    spc_port dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .sck_in(sck_pin), .sck_out, .sck_oe, .sdi_in(sdi), .sdo_out,
        .sdo_oe, .ss_in_n(ss_n), .framed_operation_enable(fr));
    spc_peer peer (.pol(ppol), .sck_pin, .sdo_pin(sdo_oe ? sdo_out : ~sdo_out), .sdi,
        .sck_drv(peer_sck), .ss_n);
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    // Write with address and data offered together
    task automatic wr(input logic [4:0] a, input logic [31:0] dat);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [4:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        s = rdata;
        r = rresp;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
        rd(a);
        `CHK("rdata", e, s)
        `CHK("rresp", er, r)
    endtask
    task automatic poll(input int b, input logic val);
        for (int k = 0; k < 400 && s[b] !== val; k++) rd(spc_pkg::ADDR_STAT);
    endtask
    // Phase bit clear in slave, never both prescalers 1:1
    function automatic logic [31:0] legal(input logic [31:0] c);
        if (!c[spc_pkg::B_MASTER]) c[spc_pkg::B_PHASE] = 1'b0;
        if (c[4:0] == 5'h1F) c[spc_pkg::B_PRIMARY_PRESCALE] = 1'b0;
        return c;
    endfunction
    // One frame each way, checked at both ends
    task automatic xfer(input logic [31:0] c, input logic ext);
        ppol = c[spc_pkg::B_POL];
        wr(spc_pkg::ADDR_CTRL1, c);
        pw = 16'($urandom());
        d = 16'($urandom());
        wr(spc_pkg::ADDR_DATA, {16'h0000, d});
        peer.tx = pw;
        peer.rx = 16'h0000;
        if (ext) peer.frame(16);
        s = 32'h0000_0000;
        poll(spc_pkg::B_RX_FULL, 1'b1);
        v = c[spc_pkg::B_WIDE] ? {16'h0000, pw} : {24'h00_0000, pw[15:8]};
        rchk(spc_pkg::ADDR_DATA, v, spc_pkg::RESP_OKAY);
        `CHK("peer_rx", c[spc_pkg::B_WIDE] ? d : d & 16'h00FF, peer.rx)
    endtask
    task automatic conclude;
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        fails++;
        conclude();
    end
    initial begin
        {awvalid, wvalid, arvalid, ppol, aresetn} = '0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, wdata} = '0;
        fails = 0;
        n_checks = 0;
        v = $urandom(32'ha0808b60);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        wr(5'h10, 32'h0000_FFFF);
        `CHK("bresp", spc_pkg::RESP_SLVERR, r)
        rchk(5'h14, 32'h0000_0000, spc_pkg::RESP_SLVERR);
        rchk(spc_pkg::ADDR_CTRL1, {16'h0000, spc_pkg::CTRL1_RST}, spc_pkg::RESP_OKAY);
        wr(spc_pkg::ADDR_CTRL2, 32'h0000_0001);
        // Random settings seen at the pins
        for (i = 0; i < 10; i++) begin
            v = (i == 0) ? 32'h0000_FFFF : $urandom();
            v = legal(v & {16'h0000, spc_pkg::CTRL1_MASK});
            wr(spc_pkg::ADDR_CTRL1, v);
            rchk(spc_pkg::ADDR_CTRL1, v, spc_pkg::RESP_OKAY);
            `CHK("sck_oe", v[spc_pkg::B_MASTER] & ~v[spc_pkg::B_CLK_DIS], sck_oe)
            if (v[spc_pkg::B_MASTER] && !v[spc_pkg::B_CLK_DIS])
                `CHK("sck_out", v[spc_pkg::B_POL], sck_out)
            if (v[spc_pkg::B_DO_DIS]) `CHK("sdo_oe", 1'b0, sdo_oe)
        end
        // Master byte and word frames, then a slave frame
        for (i = 0; i < 2; i++) xfer(32'h0000_0133 | ($urandom() & 32'h240) | (i << 10), 0);
        xfer(32'h0000_0580, 1'b1);
        // Buffer filled while stopped, then drained
        wr(spc_pkg::ADDR_CTRL2, 32'h0000_0000);
        for (i = 0; i < spc_pkg::TX_DEPTH; i++) wr(spc_pkg::ADDR_DATA, 32'(i));
        rchk(spc_pkg::ADDR_STAT, 32'h0000_0001 << spc_pkg::B_TX_FULL, spc_pkg::RESP_OKAY);
        wr(spc_pkg::ADDR_CTRL1, 32'h0000_0133);
        wr(spc_pkg::ADDR_CTRL2, 32'h0000_0003);
        `CHK("framed", 1'b1, fr)
        poll(spc_pkg::B_TX_EMPTY, 1'b1);
        poll(spc_pkg::B_BUSY, 1'b0);
        rchk(spc_pkg::ADDR_STAT, 32'h0000_000E, spc_pkg::RESP_OKAY);
        conclude();
    end
endmodule
`default_nettype wire
